/* File: loader_cmd_pkg.sv */
// constants for the loader command handler
package loader_cmd_pkg;
   localparam logic [7:0] cmd_whole_erase = 8'h01;
   localparam logic [7:0] cmd_property_write = 8'h0c;
   // region erase code not fixed by the command set, chosen here
   localparam logic [7:0] cmd_region_erase = 8'h02;
   localparam logic [31:0] tag_write_verify = 32'h0000000a;
   localparam logic [31:0] status_ok = 32'h00000000;
   localparam logic [31:0] status_bad_argument = 32'h00000004;
   localparam logic [31:0] status_misaligned = 32'h00000065;
   localparam logic [31:0] status_out_of_range = 32'h00000066;
   localparam logic [31:0] status_access_fault = 32'h00000067;
   localparam logic [31:0] status_protect_violation = 32'h00000068;
   localparam logic [31:0] status_op_failed = 32'h00000069;
   localparam logic [31:0] status_not_writable = 32'h00002712;
   localparam logic [31:0] status_bad_tag = 32'h0000271c;
   localparam logic [31:0] status_range_protected = 32'h000027d8;
   localparam logic [11:0] mem_internal = 12'h000;
   localparam logic [11:0] mem_exec_only = 12'h010;
   localparam logic [11:0] mem_quad_nor = 12'h001;
   localparam logic [11:0] mem_par_nor = 12'h008;
   localparam logic [11:0] mem_octal_nor = 12'h009;
   localparam logic [11:0] mem_raw_nand = 12'h100;
   localparam logic [11:0] mem_serial_nand = 12'h101;
   localparam logic [11:0] mem_spi_nor = 12'h110;
   localparam logic [11:0] mem_sd_card = 12'h120;
   localparam logic [11:0] mem_emmc = 12'h121;
   localparam logic [31:0] flash_size_default = 32'h00080000;
   localparam logic write_verify_reset = 1'b0;
   localparam logic [3:0] pin_sync_stages = 4'h3;
endpackage

/* File: cmd_checker.sv */
// region erase parameter checks in fixed order
`timescale 1ns/10ps
`default_nettype none
module cmd_checker
   import loader_cmd_pkg::*;
(
   // request
   input wire logic [31:0] start_addr,
   input wire logic [31:0] byte_count,
   input wire logic [31:0] flash_size,
   input wire logic range_protected,
   // verdict
   output logic [31:0] verdict
);
   logic [32:0] end_addr;
   always_comb
   begin
      end_addr = {1'b0, start_addr} + {1'b0, byte_count};
      if ((start_addr[1:0] != 2'b00) || (byte_count[1:0] != 2'b00))
         verdict = status_misaligned;
      else if (end_addr > {1'b0, flash_size})
         verdict = status_out_of_range;
      else if (range_protected)
         verdict = status_range_protected;
      else
         verdict = status_ok;
   end
endmodule
`default_nettype wire

/* File: loader_cmds.sv */
// property write, whole erase and region erase command handler
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Property write is code 0x0c with tag in word 0 and value in word 1.
// - A read-only property stays unchanged and returns the not-writable status.
// - Property write has no data phase and replies ok, not-writable or bad argument.
// - Tag 10 is writable and value 1 turns on write verification.
// - Whole erase is code 0x01 and erases the selected memory entirely.
// - Whole erase is refused with an error when any region is protected.
// - Whole erase releases security; the stored field returns it after reset.
// - Whole erase without a memory id uses the internal flash.
// - Memory ids follow the fixed encoding table.
// - Whole erase has no data phase and replies with ok or an error.
// - Region erase carries start, count and memory id and has no data phase.
// - A misaligned start or count returns the misaligned status.
// - A region outside flash returns the out-of-range status.
// - A partly protected region returns the range-protected status.
// - Region erase may also report access fault, protection violation or failure.
module loader_cmds
   import loader_cmd_pkg::*;
#(
   parameter logic [31:0] flash_size = flash_size_default
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // command packet
   input wire logic cmd_valid,
   input wire logic [7:0] command_code,
   input wire logic [7:0] param_count,
   input wire logic [31:0] param0,
   input wire logic [31:0] param1,
   input wire logic [31:0] param2,
   output logic cmd_ready,
   // common reply packet
   output logic reply_valid,
   output logic [31:0] reply_status,
   output logic [7:0] reply_code,
   // property store
   output logic write_verify_enable,
   // flash controller
   input wire logic any_protected,
   input wire logic range_protected,
   input wire logic flash_busy,
   input wire logic flash_access_err,
   input wire logic flash_protect_err,
   input wire logic flash_fail_err,
   output logic erase_all_req,
   output logic erase_range_req,
   output logic [31:0] erase_start,
   output logic [31:0] erase_count,
   output logic [11:0] erase_mem,
   output logic security_release
);
   typedef enum logic [1:0] {st_idle = 2'b00, st_start = 2'b01, st_wait = 2'b10,
      st_reply = 2'b11} state_e;
   state_e state, next_state;
   logic [31:0] region_verdict;
   logic [31:0] status, next_status;
   logic [7:0] code, next_code;
   logic wv, next_wv;
   logic all_req, next_all_req, rng_req, next_rng_req, sec, next_sec;
   logic [31:0] e_start, next_e_start, e_count, next_e_count;
   logic [11:0] e_mem, next_e_mem;
   logic [1:0] sync_busy;

   function automatic logic mem_known(input logic [31:0] id);
      case (id[11:0])
         mem_internal, mem_exec_only, mem_quad_nor, mem_par_nor, mem_octal_nor,
         mem_raw_nand, mem_serial_nand, mem_spi_nor, mem_sd_card, mem_emmc:
            mem_known = (id[31:12] == 20'h00000);
         default:
            mem_known = 1'b0;
      endcase
   endfunction

   cmd_checker u_chk
   (
      .start_addr(param0),
      .byte_count(param1),
      .flash_size(flash_size),
      .range_protected(range_protected),
      .verdict(region_verdict)
   );

   always_comb
   begin
      next_state = state;
      next_status = status;
      next_code = code;
      next_wv = wv;
      next_all_req = 1'b0;
      next_rng_req = 1'b0;
      next_sec = 1'b0;
      next_e_start = e_start;
      next_e_count = e_count;
      next_e_mem = e_mem;
      case (state)
         st_idle:
            if (cmd_valid)
            begin
               next_code = command_code;
               next_state = st_reply;
               case (command_code)
                  cmd_property_write:
                     if (param0 != tag_write_verify)
                        next_status = status_not_writable;
                     else if (param1[31:1] != 31'h00000000)
                        next_status = status_bad_argument;
                     else
                     begin
                        next_wv = param1[0];
                        next_status = status_ok;
                     end
                  cmd_whole_erase:
                  begin
                     next_e_mem = (param_count == 8'h00) ? mem_internal : param0[11:0];
                     if (param_count != 8'h00 && !mem_known(param0))
                        next_status = status_bad_argument;
                     else if (any_protected)
                        next_status = status_protect_violation;
                     else
                     begin
                        next_all_req = 1'b1;
                        next_state = st_start;
                     end
                  end
                  cmd_region_erase:
                  begin
                     next_e_start = param0;
                     next_e_count = param1;
                     next_e_mem = (param_count > 8'h02) ? param2[11:0] : mem_internal;
                     if (region_verdict != status_ok)
                        next_status = region_verdict;
                     else if (param_count > 8'h02 && !mem_known(param2))
                        next_status = status_bad_argument;
                     else
                     begin
                        next_rng_req = 1'b1;
                        next_state = st_start;
                     end
                  end
                  default:
                     next_status = status_bad_tag;
               endcase
            end
         st_start:
            // busy reaches us two flops late; wait until it shows, else stale idle ends early
            if (sync_busy[1])
               next_state = st_wait;
         st_wait:
            if (!sync_busy[1])
            begin
               next_state = st_reply;
               if (flash_access_err)
                  next_status = status_access_fault;
               else if (flash_protect_err)
                  next_status = status_protect_violation;
               else if (flash_fail_err)
                  next_status = status_op_failed;
               else
               begin
                  next_status = status_ok;
                  next_sec = (code == cmd_whole_erase);
               end
            end
         st_reply:
            next_state = st_idle;
         default:
            next_state = st_idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= st_idle;
         status <= status_ok;
         code <= 8'h00;
         wv <= write_verify_reset;
         all_req <= 1'b0;
         rng_req <= 1'b0;
         sec <= 1'b0;
         e_start <= 32'h00000000;
         e_count <= 32'h00000000;
         e_mem <= mem_internal;
         sync_busy <= 2'b00;
      end
      else if (clk_en)
      begin
         state <= next_state;
         status <= next_status;
         code <= next_code;
         wv <= next_wv;
         all_req <= next_all_req;
         rng_req <= next_rng_req;
         sec <= next_sec;
         e_start <= next_e_start;
         e_count <= next_e_count;
         e_mem <= next_e_mem;
         sync_busy <= {sync_busy[0], flash_busy};
      end
   end

   assign cmd_ready = (state == st_idle);
   assign reply_valid = (state == st_reply);
   assign reply_status = status;
   assign reply_code = code;
   assign write_verify_enable = wv;
   assign erase_all_req = all_req;
   assign erase_range_req = rng_req;
   assign erase_start = e_start;
   assign erase_count = e_count;
   assign erase_mem = e_mem;
   assign security_release = sec;
endmodule
`default_nettype wire

/* File: loader_cmds_props.sv */
// assertions on the loader command handler ports
`timescale 1ns/10ps
`default_nettype none
module loader_cmds_props
   import loader_cmd_pkg::*;
(
   // clock and command
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] command_code,
   input wire logic [7:0] param_count,
   input wire logic [31:0] param0,
   input wire logic [31:0] param1,
   // reply and flash
   input wire logic reply_valid,
   input wire logic [31:0] reply_status,
   input wire logic write_verify_enable,
   input wire logic any_protected,
   input wire logic erase_all_req,
   input wire logic erase_range_req,
   input wire logic [31:0] erase_start,
   input wire logic [31:0] erase_count,
   input wire logic [11:0] erase_mem,
   input wire logic security_release
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic tk = cmd_valid && cmd_ready && clk_en;
   wire logic pw = tk && command_code == cmd_property_write;
   wire logic wa = tk && command_code == cmd_whole_erase;
   wire logic mis = tk && command_code == cmd_region_erase &&
      (param0[1:0] != 2'h0 || param1[1:0] != 2'h0);
   AST_PW_REPLY: assert property (pw |=> reply_valid)
      else $error("no reply after property write");
   AST_VERIFY_ON: assert property (pw && param0 == tag_write_verify && param1 == 32'h1 |=> write_verify_enable && reply_status == status_ok)
      else $error("verify enable not set");
   AST_READ_ONLY: assert property (pw && param0 != tag_write_verify |=> $stable(write_verify_enable) && reply_status == status_not_writable)
      else $error("read-only property handling wrong");
   AST_PROT_ALL: assert property (wa && any_protected |=> reply_valid && !erase_all_req && reply_status == status_protect_violation)
      else $error("protected whole erase not refused");
   AST_ALL_REQ: assert property (wa && !any_protected |=> erase_all_req)
      else $error("whole erase not started");
   AST_DEF_MEM: assert property (wa && !any_protected && param_count == 8'h0 |=> erase_mem == mem_internal)
      else $error("default memory not internal");
   AST_SEC_OK: assert property (security_release |-> reply_valid && reply_status == status_ok)
      else $error("security release without ok reply");
   AST_MISALIGN: assert property (mis |=> reply_valid && !erase_range_req && reply_status == status_misaligned)
      else $error("misaligned region not refused");
   AST_RANGE_ALIGNED: assert property (erase_range_req |-> erase_start[1:0] == 2'h0 && erase_count[1:0] == 2'h0)
      else $error("misaligned region reached flash");
   cover property (security_release);
   cover property (mis);
   cover property (erase_range_req ##[3:20] reply_valid);
endmodule
bind loader_cmds loader_cmds_props u_props (.*);
`default_nettype wire

/* File: flash_model.sv */
// flash controller model answering erase requests
`timescale 1ns/10ps
`default_nettype none
module flash_model (
   // requests
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic erase_all_req,
   input wire logic erase_range_req,
   input wire logic [1:0] err_mode,
   // status
   output logic flash_busy,
   output logic flash_access_err,
   output logic flash_protect_err,
   output logic flash_fail_err
);
   logic [3:0] left;
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         left <= 4'h0;
      else if (erase_all_req || erase_range_req)
         left <= 4'h6;
      else if (left != 4'h0)
         left <= left - 4'h1;
   assign flash_busy = left != 4'h0;
   // error flags only meaningful once busy falls
   assign flash_access_err = !flash_busy && err_mode == 2'h1;
   assign flash_protect_err = !flash_busy && err_mode == 2'h2;
   assign flash_fail_err = !flash_busy && err_mode == 2'h3;
endmodule
`default_nettype wire

/* File: test_boot_property_erase_cmds.sv */
// testbench for the loader command handler
`timescale 1ns/10ps
`default_nettype none
module test_boot_property_erase_cmds;
   import loader_cmd_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cmd_valid = 1'b0, got, sec;
   logic [7:0] command_code = 8'h0, param_count = 8'h0, reply_code;
   logic [31:0] param0 = 32'h0, param1 = 32'h0, param2 = 32'h0, reply_status;
   logic any_protected = 1'b0, range_protected = 1'b0, cmd_ready, reply_valid, wve;
   logic flash_busy, f_acc, f_prot, f_fail, all_req, rng_req, sec_rel;
   logic [1:0] err_mode = 2'h0;
   logic [31:0] erase_start, erase_count;
   logic [11:0] erase_mem;
   int fails = 0, num_checks = 0, cyc = 0;
   loader_cmds DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .cmd_valid(cmd_valid), .command_code(command_code), .param_count(param_count),
      .param0(param0), .param1(param1), .param2(param2), .cmd_ready(cmd_ready),
      .reply_valid(reply_valid), .reply_status(reply_status), .reply_code(reply_code),
      .write_verify_enable(wve), .any_protected(any_protected),
      .range_protected(range_protected), .flash_busy(flash_busy),
      .flash_access_err(f_acc), .flash_protect_err(f_prot), .flash_fail_err(f_fail),
      .erase_all_req(all_req), .erase_range_req(rng_req), .erase_start(erase_start),
      .erase_count(erase_count), .erase_mem(erase_mem), .security_release(sec_rel));
   flash_model u_flash (.core_clk(core_clk), .rst_b(rst_b), .erase_all_req(all_req),
      .erase_range_req(rng_req), .err_mode(err_mode), .flash_busy(flash_busy),
      .flash_access_err(f_acc), .flash_protect_err(f_prot), .flash_fail_err(f_fail));
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic run(input logic [7:0] c, input logic [7:0] n, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] d);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      command_code <= c;
      param_count <= n;
      param0 <= a;
      param1 <= b;
      param2 <= d;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      got = 1'b0;
      // reply_valid may already stand in the cycle right after the take
      for (int i = 0; i < 300 && !got; i++)
      begin
         #1;
         got = reply_valid === 1'b1;
         sec = sec_rel === 1'b1;
         if (!got)
            @(posedge core_clk);
      end
      chk({31'h0, got}, 32'h1);
      chk({24'h0, reply_code}, {24'h0, c});
      chk({31'h0, cmd_ready}, 32'h0);
      @(posedge core_clk);
   endtask
   task automatic t_prop;
      run(cmd_property_write, 8'h2, tag_write_verify, 32'h1, 32'h0);
      chk(reply_status, status_ok);
      chk({31'h0, wve}, 32'h1);
      run(cmd_property_write, 8'h2, 32'h5, 32'h0, 32'h0);
      chk(reply_status, status_not_writable);
      chk({31'h0, wve}, 32'h1);
      run(cmd_property_write, 8'h2, tag_write_verify, 32'h3, 32'h0);
      chk(reply_status, status_bad_argument);
      run(8'h0f, 8'h0, 32'h0, 32'h0, 32'h0);
      chk(reply_status, status_bad_tag);
      $display("test property write done");
   endtask
   task automatic t_freeze;
      @(posedge core_clk);
      clk_en <= 1'b0;
      cmd_valid <= 1'b1;
      command_code <= cmd_property_write;
      param_count <= 8'h2;
      param0 <= tag_write_verify;
      param1 <= 32'h0;
      repeat (3) @(posedge core_clk);
      cmd_valid <= 1'b0;
      clk_en <= 1'b1;
      #1;
      chk({31'h0, reply_valid}, 32'h0);
      chk({31'h0, wve}, 32'h1);
      @(posedge core_clk);
      $display("test clock enable freeze done");
   endtask
   task automatic t_whole;
      any_protected <= 1'b1;
      run(cmd_whole_erase, 8'h0, 32'h0, 32'h0, 32'h0);
      chk(reply_status, status_protect_violation);
      any_protected <= 1'b0;
      run(cmd_whole_erase, 8'h0, 32'h0, 32'h0, 32'h0);
      chk(reply_status, status_ok);
      chk({31'h0, sec}, 32'h1);
      chk({20'h0, erase_mem}, {20'h0, mem_internal});
      run(cmd_whole_erase, 8'h1, {20'h0, mem_quad_nor}, 32'h0, 32'h0);
      chk({20'h0, erase_mem}, {20'h0, mem_quad_nor});
      $display("test whole erase done");
   endtask
   task automatic t_region;
      logic [31:0] st [10] = '{32'h1002, 32'h1000, 32'h7ff00, 32'h80001, 32'h1000,
         32'h7ff00, 32'h1000, 32'h1000, 32'h1000, 32'h1000};
      logic [31:0] ct [10] = '{32'h100, 32'h101, 32'h200, 32'h10, 32'h100,
         32'h200, 32'h100, 32'h100, 32'h100, 32'h100};
      logic [31:0] ex [10] = '{status_misaligned, status_misaligned, status_out_of_range,
         status_misaligned, status_range_protected, status_out_of_range, status_ok,
         status_access_fault, status_protect_violation, status_op_failed};
      for (int k = 0; k < 10; k++)
      begin
         range_protected <= k == 4 || k == 5;
         err_mode <= k > 5 ? 2'(k - 6) : 2'h0;
         run(cmd_region_erase, 8'h3, st[k], ct[k], {20'h0, mem_internal});
         chk(reply_status, ex[k]);
      end
      chk(erase_start, 32'h1000);
      chk(erase_count, 32'h100);
      chk({20'h0, erase_mem}, {20'h0, mem_internal});
      $display("test region erase done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      t_prop();
      t_freeze();
      t_whole();
      t_region();
      complete_run();
   end
endmodule
`default_nettype wire
